// ### lio_pkg.sv
// package: register map, field layout, reset values and timing counts of the local i/o block
package lio_pkg;
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned NUM_IN       = 4;
  localparam int unsigned NUM_OUT      = 3;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned WDOG_W       = 16;
  localparam int unsigned UNIT_W       = 8;
  localparam int unsigned NUM_EVT      = 3;

  // register offsets, word indices in steps of one
  localparam logic [ADDR_W-1:0] OFS_INPUTS   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUTS  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DEFAULTS = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_WDOG     = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_UNIT     = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CNT_CLR  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CNT0     = 4'hc;

  // interrupt status bit positions
  localparam int unsigned EVT_EXPIRE   = 0;
  localparam int unsigned EVT_EDGE     = 1;
  localparam int unsigned EVT_CNT_WRAP = 2;

  // reset values
  localparam logic [NUM_OUT-1:0] DEFAULTS_RST = 3'h0;
  localparam logic [WDOG_W-1:0]  WDOG_RST     = 16'h0000;
  localparam logic [UNIT_W-1:0]  UNIT_RST     = 8'h01;

  // one millisecond tick
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned TICK_CYC   = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int unsigned TICK_CNT_W = 16;
endpackage

// ### local_io.sv
// module: local digital inputs, outputs with defaults, pulse counters and a message watchdog
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: The four input levels, synchronised, can be read by the host in the input register.
// R2: A host write to the output register drives the three outputs to the written states, unless the watchdog expires in the same cycle.
// R3: Four independent pulse counters each count pulses of their own input.
// R4: Counters are read-only and cleared only by a clear-register write naming that counter.
// R5: A separate default-state register holds one default level for each output.
// R6: At reset the outputs load the default-state register's reset value.
// R7: When the watchdog expires the outputs are forced to their default states.
// R8: The watchdog restarts on each well-formed message whose unit address matches ours.
// R9: A watchdog value of zero disables expiry entirely.
// R10: A unit-address register decides which messages are addressed to this block.
// R11: The watchdog counts milliseconds and counters step on each inactive-to-active edge.
module local_io #(
  parameter int unsigned TICK_CYCLES = lio_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // register port
  input  wire logic [lio_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [lio_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [lio_pkg::DATA_W-1:0] o_rdata,
  // message decoder
  input  wire logic                       i_msg_valid,
  input  wire logic                       i_msg_ok,
  input  wire logic [lio_pkg::UNIT_W-1:0] i_msg_unit,
  // pins
  input  wire logic [lio_pkg::NUM_IN-1:0] i_din,
  output logic      [lio_pkg::NUM_OUT-1:0] o_dout,
  // interrupt
  output logic                            o_irq
);
  import lio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_IN-1:0]  sync1_reg;
  logic [NUM_IN-1:0]  sync2_reg;
  logic [NUM_IN-1:0]  prev_reg;
  logic [NUM_OUT-1:0] out_reg;
  logic [NUM_OUT-1:0] out_next;
  logic [NUM_OUT-1:0] def_reg;
  logic [WDOG_W-1:0]  wdog_cfg_reg;
  logic [UNIT_W-1:0]  unit_reg;
  logic [TICK_CNT_W-1:0] tick_reg;
  logic [WDOG_W-1:0]  ms_reg;
  logic [NUM_EVT-1:0] stat_reg;
  logic [NUM_EVT-1:0] en_reg;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  rdata_next;
  logic [CNT_W-1:0]   cnt_reg [NUM_IN];

  wire logic [NUM_IN-1:0] rise = sync2_reg & ~prev_reg; // R11
  wire logic wr_out   = i_wr && (i_addr == OFS_OUTPUTS);
  wire logic wr_def   = i_wr && (i_addr == OFS_DEFAULTS);
  wire logic wr_wdog  = i_wr && (i_addr == OFS_WDOG);
  wire logic wr_unit  = i_wr && (i_addr == OFS_UNIT);
  wire logic wr_clr   = i_wr && (i_addr == OFS_CNT_CLR);
  wire logic wr_en    = i_wr && (i_addr == OFS_IRQ_EN);
  wire logic wr_iclr  = i_wr && (i_addr == OFS_IRQ_CLR);
  wire logic msg_hit  = i_msg_valid && i_msg_ok && (i_msg_unit == unit_reg); // R8 R10
  wire logic wdog_on  = (wdog_cfg_reg != '0); // R9
  wire logic tick     = (tick_reg == TICK_CNT_W'(TICK_CYCLES - 1));
  wire logic expire   = wdog_on && !msg_hit && tick && (ms_reg == wdog_cfg_reg - 1'b1); // R7
  logic [NUM_IN-1:0] wrap;
  wire logic [NUM_EVT-1:0] evt = {|wrap, |rise, expire};

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= i_din;
      sync2_reg <= sync1_reg; // R1
      prev_reg  <= sync2_reg;
    end
  end

  // pulse counters
  generate
    for (genvar g = 0; g < NUM_IN; g++) begin : g_cnt
      assign wrap[g] = rise[g] && (cnt_reg[g] == '1);
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_reg[g] <= '0;
        end else if (wr_clr && i_wdata[g]) begin
          cnt_reg[g] <= '0; // R4
        end else if (rise[g]) begin
          cnt_reg[g] <= cnt_reg[g] + 1'b1; // R3 R11
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // config registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      def_reg      <= DEFAULTS_RST;
      wdog_cfg_reg <= WDOG_RST;
      unit_reg     <= UNIT_RST;
      en_reg       <= '0;
    end else begin
      if (wr_def) def_reg <= i_wdata[NUM_OUT-1:0]; // R5
      if (wr_wdog) wdog_cfg_reg <= i_wdata[WDOG_W-1:0];
      if (wr_unit) unit_reg <= i_wdata[UNIT_W-1:0]; // R10
      if (wr_en) en_reg <= i_wdata[NUM_EVT-1:0];
    end
  end

  // expiry takes priority over a same-cycle host write so the safe state wins
  assign out_next = expire ? def_reg : (wr_out ? i_wdata[NUM_OUT-1:0] : out_reg); // R2 R7

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_reg <= DEFAULTS_RST; // R6
    end else begin
      out_reg <= out_next;
    end
  end
  assign o_dout = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond watchdog; reconfiguring restarts the period
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_reg <= '0;
      ms_reg   <= '0;
    end else if (msg_hit || !wdog_on || wr_wdog) begin
      tick_reg <= '0; // R8 R9
      ms_reg   <= '0;
    end else if (tick) begin
      tick_reg <= '0;
      ms_reg   <= expire ? '0 : ms_reg + 1'b1; // R11
    end else begin
      tick_reg <= tick_reg + 1'b1;
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~({NUM_EVT{wr_iclr}} & i_wdata[NUM_EVT-1:0])) | evt;
    end
  end
  assign o_irq = |(stat_reg & en_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    rdata_next = '0;
    unique case (i_addr)
      OFS_INPUTS:   rdata_next[NUM_IN-1:0]  = sync2_reg; // R1
      OFS_OUTPUTS:  rdata_next[NUM_OUT-1:0] = out_reg;
      OFS_DEFAULTS: rdata_next[NUM_OUT-1:0] = def_reg;
      OFS_WDOG:     rdata_next[WDOG_W-1:0]  = wdog_cfg_reg;
      OFS_UNIT:     rdata_next[UNIT_W-1:0]  = unit_reg;
      OFS_IRQ_STAT: rdata_next[NUM_EVT-1:0] = stat_reg;
      OFS_IRQ_EN:   rdata_next[NUM_EVT-1:0] = en_reg;
      OFS_CNT0:        rdata_next = cnt_reg[0]; // R4
      OFS_CNT0 + 4'h1: rdata_next = cnt_reg[1];
      OFS_CNT0 + 4'h2: rdata_next = cnt_reg[2];
      OFS_CNT0 + 4'h3: rdata_next = cnt_reg[3];
      default:      rdata_next = '0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= i_rd ? rdata_next : '0;
    end
  end
  assign o_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_OUT_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    (wr_out && !expire) |=> (o_dout == $past(i_wdata[NUM_OUT-1:0])))
    else $error("output write not applied");
  AST_EXPIRE_DEF: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    expire |=> (o_dout == $past(def_reg)))
    else $error("expiry did not load defaults");
  AST_NO_EXPIRE_OFF: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    !wdog_on |-> !expire)
    else $error("expiry while watchdog disabled");
  AST_HIT_RESTART: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    msg_hit |=> (ms_reg == '0 && tick_reg == '0))
    else $error("matching message did not restart watchdog");
  AST_CNT_CLR: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (wr_clr && i_wdata[0]) |=> (cnt_reg[0] == '0))
    else $error("counter clear failed");
  AST_CNT_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (!rise[1] && !(wr_clr && i_wdata[1])) |=> $stable(cnt_reg[1]))
    else $error("counter changed without cause");
  AST_CNT_INC: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    (rise[2] && !(wr_clr && i_wdata[2])) |=> (cnt_reg[2] == $past(cnt_reg[2]) + 1'b1))
    else $error("counter missed a rising edge");
  AST_IN_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    (i_rd && i_addr == OFS_INPUTS) |=> (o_rdata[NUM_IN-1:0] == $past(sync2_reg)))
    else $error("input read mismatch");
  AST_OUT_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (!wr_out && !expire) |=> $stable(o_dout))
    else $error("outputs changed without cause");

  ////////////////////////////////////////////////////////////////////////////
  // read-back checks; data stand one cycle, then the port returns to zero

  AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    !i_rd |=> (o_rdata == '0))
    else $error("read data present without a read");

  AST_OUT_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    (i_rd && i_addr == OFS_OUTPUTS) |=> (o_rdata[NUM_OUT-1:0] == $past(o_dout)))
    else $error("output read mismatch");

  AST_DEF_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    (i_rd && i_addr == OFS_DEFAULTS) |=> (o_rdata[NUM_OUT-1:0] == $past(def_reg)))
    else $error("default read mismatch");

  AST_UNIT_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    (i_rd && i_addr == OFS_UNIT) |=> (o_rdata[UNIT_W-1:0] == $past(unit_reg)))
    else $error("unit address read mismatch");

  AST_WDOG_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    (i_rd && i_addr == OFS_WDOG) |=> (o_rdata[WDOG_W-1:0] == $past(wdog_cfg_reg)))
    else $error("watchdog value read mismatch");

  AST_CNT0_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (i_rd && i_addr == OFS_CNT0) |=> (o_rdata == $past(cnt_reg[0])))
    else $error("counter one read mismatch");

  AST_CNT2_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (i_rd && i_addr == OFS_CNT0 + 4'h2) |=> (o_rdata == $past(cnt_reg[2])))
    else $error("counter three read mismatch");

  AST_CNT3_READ: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (i_rd && i_addr == OFS_CNT0 + 4'h3) |=> (o_rdata == $past(cnt_reg[3])))
    else $error("counter four read mismatch");

  // configuration writes
  AST_DEF_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    wr_def |=> (def_reg == $past(i_wdata[NUM_OUT-1:0])))
    else $error("default write not applied");

  AST_DEF_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    !wr_def |=> $stable(def_reg))
    else $error("defaults changed without a write");

  AST_UNIT_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    wr_unit |=> (unit_reg == $past(i_wdata[UNIT_W-1:0])))
    else $error("unit address write not applied");

  AST_WDOG_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    wr_wdog |=> (wdog_cfg_reg == $past(i_wdata[WDOG_W-1:0])))
    else $error("watchdog value write not applied");

  AST_EN_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    wr_en |=> (en_reg == $past(i_wdata[NUM_EVT-1:0])))
    else $error("interrupt enable write not applied");

  // watchdog timing
  AST_WDOG_RESTART: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    wr_wdog |=> (ms_reg == '0 && tick_reg == '0))
    else $error("watchdog write did not restart the period");

  AST_OFF_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    !wdog_on |=> (ms_reg == '0 && tick_reg == '0))
    else $error("disabled watchdog kept counting");

  AST_TICK_RUN: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    (wdog_on && !msg_hit && !wr_wdog && !tick) |=> (tick_reg == $past(tick_reg) + 1'b1))
    else $error("prescaler stalled without a restart");

  AST_TICK_WRAP: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    tick |=> (tick_reg == '0))
    else $error("prescaler did not wrap at the tick");

  AST_MS_STEP: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (wdog_on && !msg_hit && !wr_wdog && tick && !expire) |=> (ms_reg == $past(ms_reg) + 1'b1))
    else $error("millisecond count missed a tick");

  AST_EXPIRE_WRAP: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    expire |=> (ms_reg == '0))
    else $error("period not restarted after expiry");

  AST_HIT_NO_EXPIRE: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    msg_hit |-> !expire)
    else $error("expiry in the cycle of a matching message");

  AST_BAD_MSG: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    (i_msg_valid && !i_msg_ok) |-> !msg_hit)
    else $error("malformed message restarted watchdog");

  AST_OTHER_UNIT: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    (i_msg_valid && i_msg_unit != unit_reg) |-> !msg_hit)
    else $error("foreign message restarted watchdog");

  // status, synchroniser and counters
  AST_EXPIRE_STAT: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    expire |=> stat_reg[EVT_EXPIRE])
    else $error("expiry not recorded in status");

  AST_STAT_STICKY: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    (stat_reg[EVT_EXPIRE] && !(wr_iclr && i_wdata[EVT_EXPIRE])) |=> stat_reg[EVT_EXPIRE])
    else $error("expiry status lost without a clear");

  AST_STAT_CLR: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    (wr_iclr && i_wdata[EVT_EXPIRE] && !expire) |=> !stat_reg[EVT_EXPIRE])
    else $error("expiry status not cleared");

  AST_EDGE_STAT: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    (|rise) |=> stat_reg[EVT_EDGE])
    else $error("input edge not recorded in status");

  AST_SYNC_STAGE: assert property (@(posedge i_clk) disable iff (i_rst) // R1
    sync2_reg == $past(sync1_reg))
    else $error("synchroniser stage skipped");

  AST_CNT_NO_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (i_wr && i_addr == OFS_CNT0 && !rise[0]) |=> $stable(cnt_reg[0]))
    else $error("counter accepted a host write");

  AST_CNT3_CLR: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    (wr_clr && i_wdata[3]) |=> (cnt_reg[3] == '0))
    else $error("counter four clear failed");

  COV_EXPIRE: cover property (@(posedge i_clk) disable iff (i_rst) expire);
  COV_HIT:    cover property (@(posedge i_clk) disable iff (i_rst) msg_hit && ms_reg != '0);
  COV_EDGE:   cover property (@(posedge i_clk) disable iff (i_rst) rise[0] ##1 wr_clr);
  COV_IRQ:    cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
  COV_FOREIGN: cover property (@(posedge i_clk) disable iff (i_rst) i_msg_valid && !msg_hit);
endmodule

`default_nettype wire

// ### lio_host.sv
// behavioural message source standing in for the remote host
`timescale 1ns/1ps
`default_nettype none
module lio_host (
  input  wire logic                       i_clk,
  output logic                            o_valid,
  output logic                            o_ok,
  output logic      [lio_pkg::UNIT_W-1:0] o_unit
);
  logic                       pend;
  logic                       p_ok;
  logic [lio_pkg::UNIT_W-1:0] p_unit;
  initial begin
    pend = 1'b0;
    {o_valid, o_ok, o_unit} = '0;
  end
  // qualifiers wander between messages so stale values never look valid
  always @(posedge i_clk) begin
    o_valid <= pend;
    o_ok    <= pend ? p_ok : ~o_ok;
    o_unit  <= pend ? p_unit : o_unit + 8'h35;
    pend = 1'b0;
  end
  task automatic send(input logic ok, input logic [lio_pkg::UNIT_W-1:0] unit);
    @(negedge i_clk);
    {pend, p_ok, p_unit} = {1'b1, ok, unit};
    repeat (2) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the local i/o block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lio_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, rd_d = 1'b0, m_valid, m_ok, o_irq;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [UNIT_W-1:0] m_unit;
  logic [NUM_IN-1:0] i_din;
  logic [NUM_OUT-1:0] o_dout;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] k[NUM_IN];
  int errors = 0, total_checks = 0, seed = 85855;
  local_io #(.TICK_CYCLES(4)) u_local_io (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_msg_valid(m_valid),
    .i_msg_ok(m_ok), .i_msg_unit(m_unit), .i_din(i_din), .o_dout(o_dout), .o_irq(o_irq));
  lio_host u_lio_host (.i_clk(i_clk), .o_valid(m_valid), .o_ok(m_ok), .o_unit(m_unit));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read data appear only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_d) check(o_rdata, exp_q.pop_front());
    rd_d <= i_rd;
  end
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    complete_run();
  end
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, i_din} = {1'b1, 2'h0, 4'h0, 32'h0, 4'h0};
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 check(32'(o_dout), 32'h0);
    rd(OFS_DEFAULTS, 32'h0);
    rd(OFS_UNIT, 32'h1);
    i_din <= 4'($random(seed));
    repeat (4) @(posedge i_clk);
    rd(OFS_INPUTS, 32'(i_din));
    rd(4'h9, 32'h0);
    for (int v = 0; v < 8; v++) begin
      wr(OFS_OUTPUTS, DATA_W'(v));
      check(32'(o_dout), DATA_W'(v));
    end
    i_din <= 4'h0;
    repeat (4) @(posedge i_clk);
    wr(OFS_CNT_CLR, 32'hf);
    foreach (k[g]) k[g] = DATA_W'($random(seed) & 3) + 1;
    for (int p = 0; p < 4; p++) begin
      foreach (k[g]) i_din[g] <= (k[g] > p);
      repeat (3) @(posedge i_clk);
      i_din <= 4'h0;
      repeat (3) @(posedge i_clk);
    end
    repeat (4) @(posedge i_clk);
    foreach (k[g]) rd(OFS_CNT0 + 4'(g), k[g]);
    wr(OFS_CNT_CLR, 32'h2);
    wr(OFS_CNT0, 32'hdead);
    k[1] = 0;
    foreach (k[g]) rd(OFS_CNT0 + 4'(g), k[g]);
    wr(OFS_DEFAULTS, 32'h5);
    wr(OFS_UNIT, 32'h5a);
    wr(OFS_OUTPUTS, 32'h2);
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_IRQ_CLR, 32'h7);
    wr(OFS_WDOG, 32'h3);
    repeat (6) begin
      repeat (6) @(posedge i_clk);
      u_lio_host.send(1'b1, 8'h5a);
      check(32'(o_dout), 32'h2);
    end
    u_lio_host.send(1'b1, 8'h01);
    u_lio_host.send(1'b0, 8'h5a);
    repeat (16) @(posedge i_clk);
    #1 check(32'(o_dout), 32'h5);
    check(32'(o_irq), 32'h1);
    wr(OFS_WDOG, 32'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    check(32'(o_irq), 32'h0);
    wr(OFS_OUTPUTS, 32'h6);
    repeat (100) @(posedge i_clk);
    #1 check(32'(o_dout), 32'h6);
    repeat (3) @(posedge i_clk);
    complete_run();
  end
endmodule
`default_nettype wire
